// >>> verilog/usr_core.sv
// serial transceiver status, control and data registers on a wishbone slave
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "usr_cfg.svh"
// Notes on behaviour
// R01: tx event on each load into shifter (00) or load leaving buffer empty (10)
// R02: tx event after last frame fully sent (01); code 11 is reserved
// R03: inversion bit sets idle level; infrared coding reverses its meaning
// R04: break sends start, twelve zeros, stop; request bit self clears after
// R05: enable drives pin; clearing aborts frame, empties buffer, frees pin
// R06: buffer full flag reads one when no slot is free
// R07: all-empty flag is one only with shifter and buffer empty; resets one
// R08: rx event on every push, or push reaching three or four characters
// R09: address detect drops chars with ninth bit clear, only in 9-bit mode
// R10: receiver idle flag is one when idle, resets to one
// R11: parity and framing flags belong to the head character
// R12: overrun set by hardware; software clear flushes queue and receiver
// R13: data available is one while queue holds a character
// R14: software writes data in bits 7:0, ninth bit in bit 8
// R15: receive register shows head data and ninth bit; upper bits zero
// R16: reading receive data pops the queue, next head shows its flags
// R17: data select: 11 nine bits, 10 odd, 01 even, 00 no parity
// R18: infrared coding pulses the output; the input is always read as plain serial
// R19: a char arriving on full queue sets overrun; input dropped until clear
module usr_core (
   // system
   input  wire logic               i_sys_clk,
   input  wire logic               i_sys_rst,
   // wishbone slave
   input  wire usr_pkg::usr_wbreq_s i_wb,
   output logic                    o_wb_ack,
   output logic [31:0]             o_wb_dat,
   // serial line
   input  wire logic               i_serial_in_pin,
   output logic                    o_serial_out_pin,
   output logic                    o_serial_out_drive,
   // events
   output logic                    o_tx_irq,
   output logic                    o_rx_irq
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic ack_ff, nxt_ack, txinv_ff, nxt_txinv, txbrk_ff, nxt_txbrk;
   logic txen_ff, nxt_txen, address_detect_enable_ff, nxt_address_detect_enable, overrun_error_flag_ff, nxt_overrun_error_flag;
   logic infrared_coding_enable_ff, nxt_infrared_coding_enable, tbrk_ff, nxt_tbrk, pin_ff, nxt_pin;
   logic drv_ff, txirq_ff, nxt_txirq, rxirq_ff, nxt_rxirq, rin_ff;
   logic [31:0] rdat_ff, nxt_rdat;
   logic [1:0]  txisel_ff, nxt_txisel, rxisel_ff, nxt_rxisel;
   logic [1:0]  parity_data_select_ff, nxt_parity_data_select, twp_ff, nxt_twp, trp_ff, nxt_trp;
   logic [1:0]  rwp_ff, nxt_rwp, rrp_ff, nxt_rrp;
   logic [2:0]  tcnt_ff, nxt_tcnt, rcnt_ff, nxt_rcnt;
   logic [15:0] div_ff, nxt_div, tdiv_ff, nxt_tdiv, rdiv_ff, nxt_rdiv;
   logic [13:0] tsh_ff, nxt_tsh;
   logic [9:0]  rsh_ff, nxt_rsh;
   logic [3:0]  tbits_ff, nxt_tbits, rbits_ff, nxt_rbits;
   logic [8:0]  txq_ff [0:3];
   logic [8:0]  nxt_txq [0:3];
   usr_pkg::usr_rxent_s rxq_ff [0:3];
   usr_pkg::usr_rxent_s nxt_rxq [0:3];
   usr_pkg::usr_rxent_s head, ent;
   usr_pkg::usr_tx_e tst_ff, nxt_tst;
   usr_pkg::usr_rx_e rst_ff, nxt_rst;
   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   logic acc, wr, rd, hit_sta, hit_txd, hit_rxd, hit_cfg, nine, rxda, tx_all_empty_flag;
   logic tx_push, rx_pop, overrun_error_flag_clr, txen_off, tload, brk_done;
   logic rx_push, rx_ovf, rx_done, idle_lvl;
   logic [15:0] sta_val;
   assign acc      = i_wb.cyc & i_wb.stb & ~ack_ff;
   assign wr       = acc & i_wb.we;
   assign rd       = acc & ~i_wb.we;
   assign hit_sta  = i_wb.adr == `USR_OFS_STA;
   assign hit_txd  = i_wb.adr == `USR_OFS_TXD;
   assign hit_rxd  = i_wb.adr == `USR_OFS_RXD;
   assign hit_cfg  = i_wb.adr == `USR_OFS_CFG;
   assign nine     = parity_data_select_ff == 2'h3;
   assign head     = rxq_ff[rrp_ff];
   assign rxda     = rcnt_ff != 3'h0;                           // R13
   assign tx_all_empty_flag     = (tst_ff == usr_pkg::TX_IDLE) && (tcnt_ff == 3'h0); // R07
   assign tx_push  = wr & hit_txd & i_wb.sel[0] & (tcnt_ff != `USR_QDEPTH);
   assign rx_pop   = rd & hit_rxd & rxda;                       // R16
   assign overrun_error_flag_clr = wr & hit_sta & i_wb.sel[0] & ~i_wb.dat[`USR_B_OVERRUN_ERROR_FLAG] & overrun_error_flag_ff;
   assign txen_off = wr & hit_sta & i_wb.sel[1] & ~i_wb.dat[`USR_B_TXEN] & txen_ff;
   assign idle_lvl = infrared_coding_enable_ff ? txinv_ff : ~txinv_ff;            // R03
   // flags of the head only, masked when nothing is queued
   assign sta_val = {txisel_ff[1], txinv_ff, txisel_ff[0], 1'b0, txbrk_ff, txen_ff,
                     tcnt_ff == `USR_QDEPTH, tx_all_empty_flag, rxisel_ff, address_detect_enable_ff,
                     rst_ff == usr_pkg::RX_IDLE, head.parity_error_flag & rxda,
                     head.framing_error_flag & rxda, overrun_error_flag_ff, rxda};           // R06 R10 R11
   // ------------------------------------------------------------------
   // registers and bus answer
   // ------------------------------------------------------------------
   always_comb begin
      nxt_ack    = acc;
      nxt_rdat   = rdat_ff;
      nxt_txisel = txisel_ff;
      nxt_txinv  = txinv_ff;
      nxt_txbrk  = brk_done ? 1'b0 : txbrk_ff;                  // R04
      nxt_txen   = txen_ff;
      nxt_rxisel = rxisel_ff;
      nxt_address_detect_enable  = address_detect_enable_ff;
      nxt_overrun_error_flag   = overrun_error_flag_clr ? 1'b0 : overrun_error_flag_ff;                   // R12
      if (rx_ovf) begin
         nxt_overrun_error_flag = 1'b1;                                       // R19
      end
      nxt_div    = div_ff;
      nxt_parity_data_select  = parity_data_select_ff;
      nxt_infrared_coding_enable   = infrared_coding_enable_ff;
      if (rd) begin
         nxt_rdat = 32'h0;
         if (hit_sta) begin
            nxt_rdat[15:0] = sta_val;
         end else if (hit_rxd) begin
            nxt_rdat[8:0] = rxda ? head.data : 9'h0;            // R15
         end else if (hit_cfg) begin
            nxt_rdat[18:0] = {infrared_coding_enable_ff, parity_data_select_ff, div_ff};
         end
      end
      if (wr && hit_sta && i_wb.sel[1]) begin
         nxt_txisel = {i_wb.dat[`USR_B_TXISEL1], i_wb.dat[`USR_B_TXISEL0]};
         nxt_txinv  = i_wb.dat[`USR_B_TXINV];
         nxt_txbrk  = i_wb.dat[`USR_B_TXBRK];
         nxt_txen   = i_wb.dat[`USR_B_TXEN];
      end
      if (wr && hit_sta && i_wb.sel[0]) begin
         nxt_rxisel = i_wb.dat[`USR_B_RXISEL -: 2];
         nxt_address_detect_enable  = i_wb.dat[`USR_B_ADDRESS_DETECT_ENABLE];
      end
      if (wr && hit_cfg) begin
         if (i_wb.sel[0]) nxt_div[7:0] = i_wb.dat[7:0];
         if (i_wb.sel[1]) nxt_div[15:8] = i_wb.dat[15:8];
         if (i_wb.sel[2]) begin
            nxt_parity_data_select = i_wb.dat[`USR_B_PARITY_DATA_SELECT +: 2];
            nxt_infrared_coding_enable  = i_wb.dat[`USR_B_INFRARED_CODING_ENABLE];
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0;
         {txisel_ff, txinv_ff, txbrk_ff, txen_ff} <= 5'h0;
         {rxisel_ff, address_detect_enable_ff, overrun_error_flag_ff} <= 4'h0;
         div_ff <= `USR_DIV_RST;
         parity_data_select_ff <= 2'h0;
         infrared_coding_enable_ff <= 1'b0;
      end else begin
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
         {txisel_ff, txinv_ff, txbrk_ff, txen_ff} <= {nxt_txisel, nxt_txinv, nxt_txbrk, nxt_txen};
         {rxisel_ff, address_detect_enable_ff, overrun_error_flag_ff} <= {nxt_rxisel, nxt_address_detect_enable, nxt_overrun_error_flag};
         div_ff <= nxt_div;
         parity_data_select_ff <= nxt_parity_data_select;
         infrared_coding_enable_ff <= nxt_infrared_coding_enable;
      end
   end
   // ------------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------------
   always_comb begin
      nxt_txq   = txq_ff;
      nxt_twp   = twp_ff;
      nxt_trp   = trp_ff;
      nxt_tst   = tst_ff;
      nxt_tsh   = tsh_ff;
      nxt_tbits = tbits_ff;
      nxt_tdiv  = tdiv_ff;
      nxt_tbrk  = tbrk_ff;
      nxt_txirq = 1'b0;
      tload     = 1'b0;
      brk_done  = 1'b0;
      if (tx_push) begin
         nxt_txq[twp_ff] = i_wb.dat[8:0];                       // R14
         nxt_twp = twp_ff + 2'h1;
      end
      case (tst_ff)
         usr_pkg::TX_IDLE: begin
            if (txen_ff && tcnt_ff != 3'h0) begin
               tload    = 1'b1;
               nxt_trp  = trp_ff + 2'h1;
               nxt_tst  = usr_pkg::TX_SHIFT;
               nxt_tdiv = div_ff;
               nxt_tbrk = txbrk_ff;
               if (txbrk_ff) begin
                  nxt_tsh = {1'b1, 12'h0, 1'b0};                // R04
                  nxt_tbits = 4'he;
               end else if (nine) begin
                  nxt_tsh = {4'hf, txq_ff[trp_ff], 1'b0};       // R17
                  nxt_tbits = 4'hb;
               end else if (parity_data_select_ff != 2'h0) begin
                  nxt_tsh = {4'hf, ^txq_ff[trp_ff][7:0] ^ parity_data_select_ff[1],
                             txq_ff[trp_ff][7:0], 1'b0};        // R17
                  nxt_tbits = 4'hb;
               end else begin
                  nxt_tsh = {5'h1f, txq_ff[trp_ff][7:0], 1'b0};
                  nxt_tbits = 4'ha;
               end
               nxt_txirq = (txisel_ff == 2'h0) ||
                           (txisel_ff == 2'h2 && tcnt_ff == 3'h1); // R01
            end
         end
         usr_pkg::TX_SHIFT: begin
            if (tdiv_ff <= 16'h1) begin
               nxt_tdiv  = div_ff;
               nxt_tsh   = {1'b1, tsh_ff[13:1]};
               nxt_tbits = tbits_ff - 4'h1;
               if (tbits_ff == 4'h1) begin
                  nxt_tst  = usr_pkg::TX_IDLE;
                  nxt_tbrk = 1'b0;
                  brk_done = tbrk_ff;                           // R04
                  nxt_txirq = txisel_ff == 2'h1 && tcnt_ff == 3'h0; // R02
               end
            end else begin
               nxt_tdiv = tdiv_ff - 16'h1;
            end
         end
         default: nxt_tst = usr_pkg::TX_IDLE;
      endcase
      nxt_tcnt = tcnt_ff + {2'h0, tx_push} - {2'h0, tload};
      if (txen_off) begin                                       // R05
         nxt_twp   = 2'h0;
         nxt_trp   = 2'h0;
         nxt_tcnt  = 3'h0;
         nxt_tst   = usr_pkg::TX_IDLE;
         nxt_tbrk  = 1'b0;
         nxt_txirq = 1'b0;
      end
      // infrared: a zero is a pulse in the first quarter of the bit only
      if (tst_ff != usr_pkg::TX_SHIFT || tsh_ff[0]) begin
         nxt_pin = idle_lvl;                                    // R03
      end else if (infrared_coding_enable_ff) begin
         nxt_pin = (tdiv_ff > div_ff - {2'h0, div_ff[15:2]}) ? ~idle_lvl : idle_lvl; // R18
      end else begin
         nxt_pin = ~idle_lvl;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < 4; i++) txq_ff[i] <= 9'h0;
         {twp_ff, trp_ff, tcnt_ff} <= 7'h0;
         tst_ff <= usr_pkg::TX_IDLE;
         tsh_ff <= 14'h3fff;
         tbits_ff <= 4'h0;
         tdiv_ff <= 16'h0;
         tbrk_ff <= 1'b0;
         pin_ff <= 1'b1;
         drv_ff <= 1'b0;
         txirq_ff <= 1'b0;
      end else begin
         txq_ff <= nxt_txq;
         {twp_ff, trp_ff, tcnt_ff} <= {nxt_twp, nxt_trp, nxt_tcnt};
         tst_ff <= nxt_tst;
         tsh_ff <= nxt_tsh;
         tbits_ff <= nxt_tbits;
         tdiv_ff <= nxt_tdiv;
         tbrk_ff <= nxt_tbrk;
         pin_ff <= nxt_pin;
         drv_ff <= txen_ff;                                     // R05
         txirq_ff <= nxt_txirq;
      end
   end
   // ------------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------------
   always_comb begin
      nxt_rxq   = rxq_ff;
      nxt_rwp   = rwp_ff;
      nxt_rrp   = rx_pop ? rrp_ff + 2'h1 : rrp_ff;              // R16
      nxt_rst   = rst_ff;
      nxt_rsh   = rsh_ff;
      nxt_rbits = rbits_ff;
      nxt_rdiv  = rdiv_ff - 16'h1;
      nxt_rxirq = 1'b0;
      rx_done   = 1'b0;
      rx_push   = 1'b0;
      rx_ovf    = 1'b0;
      ent.framing_error_flag  = ~rin_ff;
      ent.parity_error_flag  = (parity_data_select_ff == 2'h1 || parity_data_select_ff == 2'h2) && (^rsh_ff[9:1] ^ parity_data_select_ff[1]);
      ent.data  = nine ? rsh_ff[9:1] :
                  (parity_data_select_ff != 2'h0) ? {1'b0, rsh_ff[8:1]} : {1'b0, rsh_ff[9:2]};
      case (rst_ff)
         usr_pkg::RX_IDLE: begin
            if (!rin_ff) begin
               nxt_rst  = usr_pkg::RX_START;
               nxt_rdiv = {1'b0, div_ff[15:1]};
            end
         end
         usr_pkg::RX_START: begin
            if (rdiv_ff <= 16'h1) begin
               nxt_rdiv  = div_ff;
               nxt_rbits = (parity_data_select_ff != 2'h0) ? 4'h9 : 4'h8;
               nxt_rst   = rin_ff ? usr_pkg::RX_IDLE : usr_pkg::RX_DATA;
            end
         end
         usr_pkg::RX_DATA: begin
            if (rdiv_ff <= 16'h1) begin
               nxt_rdiv  = div_ff;
               nxt_rsh   = {rin_ff, rsh_ff[9:1]};
               nxt_rbits = rbits_ff - 4'h1;
               if (rbits_ff == 4'h1) nxt_rst = usr_pkg::RX_STOP;
            end
         end
         usr_pkg::RX_STOP: begin
            if (rdiv_ff <= 16'h1) begin
               nxt_rst = usr_pkg::RX_IDLE;
               rx_done = 1'b1;
            end
         end
         default: nxt_rst = usr_pkg::RX_IDLE;
      endcase
      // address filter only bites in nine-bit mode
      if (rx_done && !(address_detect_enable_ff && nine && !ent.data[8]) && !overrun_error_flag_ff) begin // R09 R19
         if (rcnt_ff == `USR_QDEPTH && !rx_pop) begin
            rx_ovf = 1'b1;                                      // R12
         end else begin
            rx_push = 1'b1;
            nxt_rxq[rwp_ff] = ent;                              // R11
            nxt_rwp = rwp_ff + 2'h1;
         end
      end
      nxt_rcnt = rcnt_ff + {2'h0, rx_push} - {2'h0, rx_pop};
      nxt_rxirq = rx_push && (!rxisel_ff[1] || (rxisel_ff[0] ? nxt_rcnt == 3'h4
                                                             : nxt_rcnt == 3'h3)); // R08
      if (overrun_error_flag_clr) begin                                       // R12
         nxt_rwp  = 2'h0;
         nxt_rrp  = 2'h0;
         nxt_rcnt = 3'h0;
         nxt_rst  = usr_pkg::RX_IDLE;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < 4; i++) rxq_ff[i] <= '0;
         {rwp_ff, rrp_ff, rcnt_ff} <= 7'h0;
         rst_ff <= usr_pkg::RX_IDLE;
         rsh_ff <= 10'h0;
         rbits_ff <= 4'h0;
         rdiv_ff <= 16'h0;
         rxirq_ff <= 1'b0;
         rin_ff <= 1'b1;
      end else begin
         rxq_ff <= nxt_rxq;
         {rwp_ff, rrp_ff, rcnt_ff} <= {nxt_rwp, nxt_rrp, nxt_rcnt};
         rst_ff <= nxt_rst;
         rsh_ff <= nxt_rsh;
         rbits_ff <= nxt_rbits;
         rdiv_ff <= nxt_rdiv;
         rxirq_ff <= nxt_rxirq;
         rin_ff <= i_serial_in_pin;
      end
   end

   assign o_wb_ack = ack_ff;
   assign o_wb_dat = rdat_ff;
   assign o_serial_out_pin = pin_ff;
   assign o_serial_out_drive = drv_ff;
   assign o_tx_irq = txirq_ff;
   assign o_rx_irq = rxirq_ff;
   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   AST_TX_LOAD_IRQ: assert property (tload && txisel_ff == 2'h0 && !txen_off |=> o_tx_irq) // R01
      else $error("no tx event on load");
   AST_TX_DONE_IRQ: assert property (tst_ff == usr_pkg::TX_SHIFT && tbits_ff == 4'h1 && // R02
      tdiv_ff <= 16'h1 && txisel_ff == 2'h1 && tcnt_ff == 3'h0 && !txen_off |=> o_tx_irq)
      else $error("no tx event at end");
   AST_IDLE_LEVEL: assert property ($past(tst_ff) == usr_pkg::TX_IDLE |-> // R03
      o_serial_out_pin == ($past(infrared_coding_enable_ff) ? $past(txinv_ff) : !$past(txinv_ff)))
      else $error("wrong idle level");
   AST_BRK_CLEAR: assert property (brk_done && !wr |=> !txbrk_ff) // R04
      else $error("break request kept");
   AST_TXEN_OFF: assert property (txen_off |=> tcnt_ff == 3'h0 ##1 !o_serial_out_drive) // R05
      else $error("disable did not flush");
   AST_TX_ALL_EMPTY_FLAG_LOW: assert property (tx_push |=> !tx_all_empty_flag) // R07
      else $error("empty flag high after write");
   AST_RX_IRQ_FULL: assert property (rx_push && rxisel_ff == 2'h3 && nxt_rcnt != 3'h4 // R08
      |=> !o_rx_irq) else $error("rx event too early");
   AST_ADDR_DROP: assert property (rx_done && address_detect_enable_ff && nine && !ent.data[8] // R09
      |-> !rx_push) else $error("data char kept in address mode");
   AST_OVERRUN_ERROR_FLAG_FLUSH: assert property (overrun_error_flag_clr |=> rcnt_ff == 3'h0 && !overrun_error_flag_ff) // R12
      else $error("overrun clear did not flush");
   AST_OVR_HOLD: assert property (rx_ovf |=> overrun_error_flag_ff && !rx_push) // R19
      else $error("overrun not held");
   AST_POP: assert property (rx_pop && !rx_push |=> rcnt_ff == $past(rcnt_ff) - 3'h1) // R16
      else $error("read did not pop");
   AST_RXDA_READ: assert property (rd && hit_sta |=> // R13
      o_wb_ack && o_wb_dat[0] == $past(rxda)) else $error("bad data available read");
   COV_BREAK: cover property (brk_done);
   COV_OVERRUN: cover property (rx_ovf);
   COV_RX_FULL_IRQ: cover property (o_rx_irq && rcnt_ff == 3'h4);
   COV_TX_DONE: cover property (o_tx_irq && txisel_ff == 2'h1);
endmodule : usr_core
`default_nettype wire

// >>> verilog/usr_cfg.svh
// register map, field positions, reset values and timing of the serial unit
`ifndef USR_CFG_SVH
`define USR_CFG_SVH
// ------------------------------------------------------------------
// byte offsets on the bus
// ------------------------------------------------------------------
`define USR_OFS_STA   8'h00
`define USR_OFS_TXD   8'h04
`define USR_OFS_RXD   8'h08
`define USR_OFS_CFG   8'h0c
// ------------------------------------------------------------------
// status/control fields
// ------------------------------------------------------------------
`define USR_B_TXISEL1 15
`define USR_B_TXINV   14
`define USR_B_TXISEL0 13
`define USR_B_TXBRK   11
`define USR_B_TXEN    10
`define USR_B_RXISEL  7
`define USR_B_ADDRESS_DETECT_ENABLE   5
`define USR_B_OVERRUN_ERROR_FLAG    1
// ------------------------------------------------------------------
// config fields: divider 15:0, data select 17:16, infrared 18
// ------------------------------------------------------------------
`define USR_B_PARITY_DATA_SELECT   16
`define USR_B_INFRARED_CODING_ENABLE    18
// ------------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------------
`define USR_STA_RST   16'h0110
`define USR_QDEPTH    3'h4
`define USR_CLK_HZ    100000000
`define USR_BAUD_BPS  115200
`define USR_DIV_RST   16'(`USR_CLK_HZ / `USR_BAUD_BPS)
`endif

// >>> verilog/usr_pkg.sv
// types shared by the serial unit
package usr_pkg;
   typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} usr_tx_e;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11, RX_STOP = 2'b10
   } usr_rx_e;
   typedef struct packed {
      logic       parity_error_flag;
      logic       framing_error_flag;
      logic [8:0] data;
   } usr_rxent_s;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } usr_wbreq_s;
endpackage : usr_pkg

// >>> testbench/usr_peer.sv
// remote serial peer: drives the unit's receive line and captures its transmit line
`timescale 1ns/1ps
`default_nettype none
module usr_peer #(
   parameter int DIV = 8
) (
   // clock
   input  wire logic i_sys_clk,
   // serial line
   input  wire logic i_line_from_dut,
   input  wire logic i_line_driven,
   output logic      o_line_to_dut
);
   // ------------------------------------------------------------------
   // frames into the unit
   // ------------------------------------------------------------------
   logic [7:0] got_q[$];
   // line idles high between frames, like a pulled-up wire
   initial o_line_to_dut = 1'b1;
   // start, eight data bits lsb first, one stop; frames may follow back to back
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_line_to_dut <= f[i];
         repeat (DIV) @(posedge i_sys_clk);
      end
   endtask : send
   // ------------------------------------------------------------------
   // frames out of the unit
   // ------------------------------------------------------------------
   // samples mid bit; a bad stop bit leaves the frame out of the queue
   initial begin : capture
      logic [7:0] b;
      forever begin
         @(posedge i_sys_clk);
         if (i_line_driven === 1'b1 && i_line_from_dut === 1'b0) begin
            repeat (DIV / 2) @(posedge i_sys_clk);
            for (int i = 0; i < 8; i++) begin
               repeat (DIV) @(posedge i_sys_clk);
               b[i] = i_line_from_dut;
            end
            repeat (DIV) @(posedge i_sys_clk);
            if (i_line_from_dut === 1'b1) got_q.push_back(b);
         end
      end
   end
endmodule : usr_peer
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the serial status, control and data registers
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   localparam int       DIV = 8;
   logic                clk;
   logic                rst;
   usr_pkg::usr_wbreq_s wb;
   logic                ack;
   logic [31:0]         rdat;
   logic                rxl;
   logic                txl;
   logic                drv;
   logic                txirq;
   logic                rxirq;
   int                  miscompares;
   int                  n_checks;
   int                  n_txirq;
   int                  n_rxirq;
   logic [31:0]         lfsr;
   logic [31:0]         q;
   logic [7:0]          b;
   logic [7:0]          exp_q[$];
   usr_core u_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_wb(wb), .o_wb_ack(ack),
      .o_wb_dat(rdat), .i_serial_in_pin(rxl), .o_serial_out_pin(txl),
      .o_serial_out_drive(drv), .o_tx_irq(txirq), .o_rx_irq(rxirq));
   usr_peer #(.DIV(DIV)) u_peer (.i_sys_clk(clk), .i_line_from_dut(txl),
      .i_line_driven(drv), .o_line_to_dut(rxl));
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] nxt_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt_rand
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask : chk
   // classic cycle: held until ack is sampled, then released for a cycle
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      n = 0;
      wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      if (n >= 50) chk("ack", 32'h1, 32'h0);
      wb <= '0;
      @(posedge clk);
   endtask : bus
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   // ------------------------------------------------------------------
   // clock, event counters, watchdog
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (txirq === 1'b1) n_txirq++;
      if (rxirq === 1'b1) n_rxirq++;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      close_out();
   end
   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      wb = '0;
      lfsr = 32'h00016361;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, 8'h00, 32'h0, q); chk("status", 32'h00000110, q);
      bus(1'b0, 8'h10, 32'h0, q); chk("unmapped", 32'h0, q);
      bus(1'b0, 8'h04, 32'h0, q); chk("txd_read", 32'h0, q);
      $display("test reset values done");
      // transmit one random character; code 11 of the event select never used
      bus(1'b1, 8'h0c, DIV, q);
      bus(1'b1, 8'h00, 32'h00000400, q); chk("drive", 32'h1, {31'h0, drv});
      lfsr = nxt_rand(lfsr);
      b = lfsr[7:0];
      bus(1'b1, 8'h04, {24'h0, b}, q);
      bus(1'b0, 8'h00, 32'h0, q); chk("all_empty", 32'h0, {31'h0, q[8]});
      for (int n = 0; n < 2000 && u_peer.got_q.size() == 0; n++) @(posedge clk);
      chk("tx_char", {24'h0, b}, {24'h0, u_peer.got_q.pop_front()});
      repeat (4 * DIV) @(posedge clk);
      bus(1'b0, 8'h00, 32'h0, q); chk("status", 32'h00000510, q);
      chk("tx_irq", 32'h1, n_txirq);
      $display("test transmit done");
      // five characters into a four-deep queue: the last one overruns
      bus(1'b1, 8'h00, 32'h000004c0, q);
      for (int i = 0; i < 5; i++) begin
         lfsr = nxt_rand(lfsr);
         if (i < 4) exp_q.push_back(lfsr[7:0]);
         u_peer.send(lfsr[7:0]);
      end
      repeat (2 * DIV) @(posedge clk);
      chk("rx_irq", 32'h1, n_rxirq);
      bus(1'b0, 8'h00, 32'h0, q); chk("status", 32'h000005d3, q);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 8'h08, 32'h0, q);
         chk("rx_data", {24'h0, exp_q.pop_front()}, q);
      end
      bus(1'b0, 8'h00, 32'h0, q); chk("status", 32'h000005d2, q);
      $display("test receive overrun done");
      // clearing overrun lets characters in again
      bus(1'b1, 8'h00, 32'h00000400, q);
      bus(1'b0, 8'h00, 32'h0, q); chk("status", 32'h00000510, q);
      lfsr = nxt_rand(lfsr);
      u_peer.send(lfsr[7:0]);
      repeat (2 * DIV) @(posedge clk);
      bus(1'b0, 8'h08, 32'h0, q); chk("rx_data", {24'h0, lfsr[7:0]}, q);
      chk("rx_irq", 32'h2, n_rxirq);
      $display("test overrun clear done");
      // disable, fill the queue while off, then send it in end-of-transfer event mode
      bus(1'b1, 8'h00, 32'h0, q); chk("drive", 32'h0, {31'h0, drv});
      bus(1'b0, 8'h00, 32'h0, q); chk("status", 32'h00000110, q);
      for (int i = 0; i < 5; i++) begin
         lfsr = nxt_rand(lfsr);
         if (i < 4) exp_q.push_back(lfsr[7:0]);
         bus(1'b1, 8'h04, {24'h0, lfsr[7:0]}, q);
      end
      bus(1'b0, 8'h00, 32'h0, q); chk("status", 32'h00000210, q);
      bus(1'b1, 8'h00, 32'h00002400, q);
      for (int n = 0; n < 2000 && u_peer.got_q.size() < 4; n++) @(posedge clk);
      repeat (2 * DIV) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         chk("tx_char", {24'h0, exp_q.pop_front()}, {24'h0, u_peer.got_q.pop_front()});
      end
      chk("tx_irq", 32'h2, n_txirq);
      bus(1'b0, 8'h00, 32'h0, q); chk("status", 32'h00002510, q);
      $display("test transmit queue done");
      close_out();
   end
endmodule : tb
`default_nettype wire
